// ===== rtl/dma_channel.sv
`timescale 1ns/10ps
`include "dma_regs.svh"

module dma_channel
   import dma_pkg::*;
#(
   parameter int FIFO_DEPTH = `DMA_FIFO_DEPTH,
   parameter int NUM_HS     = `DMA_NUM_HS
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // Setup
   input  wire ch_cfg_t           cfg,
   input  wire logic              start,
   // Handshake requests
   input  wire logic [NUM_HS-1:0] hs_req,
   input  wire logic [NUM_HS-1:0] hs_single,
   input  wire logic              sw_req,
   input  wire logic              sw_single,
   // Master port side
   output bus_req_t               bus_req,
   input  wire logic              bus_done,
   input  wire logic [31:0]       bus_rdata,
   // Status
   output logic [NUM_HS-1:0]      hs_ack,
   output logic                   sw_ack,
   output logic                   active,
   output logic                   done,
   output logic                   irq_evt
);

   // The 5-bit item index must reach every FIFO word
   if (FIFO_DEPTH < `DMA_MAX_BURST || FIFO_DEPTH > 31
         || NUM_HS > 15) begin : g_bad_param
      $error("dma_channel: unsupported FIFO_DEPTH or NUM_HS");
   end

   typedef struct packed {
      ch_state_t                    st;
      ch_cfg_t                      cfg;
      logic [31:0]                  sa;
      logic [31:0]                  da;
      logic [15:0]                  left;
      logic [4:0]                   len;
      logic [4:0]                   idx;
      logic [FIFO_DEPTH-1:0][31:0]  fifo;
      logic                         src_ack;
      logic                         dst_ack;
      logic                         done;
   } chan_t;

   chan_t      s_q;
   chan_t      s_d;
   logic [1:0] sreq;
   logic [1:0] dreq;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Returns {request, single} for the chosen handshake kind
   function automatic logic [1:0] hs_view(hs_kind_t k, logic [3:0] i,
         logic [NUM_HS-1:0] rq, logic [NUM_HS-1:0] sg,
         logic swr, logic sws);
      logic [1:0] r;
      r = 2'b00;
      if (k == HS_SW)
         r = {swr, sws};
      else if (32'(i) < NUM_HS && k == HS_PIRQ)
         r = {rq[i], 1'b0};
      else if (32'(i) < NUM_HS)
         r = {rq[i], sg[i]};
      return r;
   endfunction

   // Items in the next transaction, never past the block end
   function automatic logic [4:0] txn_len(logic single, logic [4:0] b,
         logic [15:0] left);
      logic [4:0] l;
      l = (b == 5'h00) ? `DMA_SINGLE_LEN : b;
      if (single)
         l = `DMA_SINGLE_LEN;
      else if ({11'h000, l} > left)
         l = left[4:0];
      // Never more than the FIFO holds, whatever burst_len says
      if (32'(l) > FIFO_DEPTH)
         l = 5'(FIFO_DEPTH);
      return l;
   endfunction

   function automatic logic [NUM_HS-1:0] onehot(logic [3:0] i);
      logic [NUM_HS-1:0] v;
      v = '0;
      if (32'(i) < NUM_HS)
         v[i] = 1'b1;
      return v;
   endfunction

   // ----------------------------------------------------------------
   // Channel sequencer
   // ----------------------------------------------------------------
   // Index only used for non-memory ends; selectable per transfer
   assign sreq = hs_view(s_q.cfg.src_kind, s_q.cfg.src_hs, hs_req,
                         hs_single, sw_req, sw_single);
   assign dreq = hs_view(s_q.cfg.dst_kind, s_q.cfg.dst_hs, hs_req,
                         hs_single, sw_req, sw_single);

   // Block length is always ours; no peripheral end-of-block input
   always_comb begin
      s_d         = s_q;
      s_d.src_ack = 1'b0;
      s_d.dst_ack = 1'b0;
      s_d.done    = 1'b0;
      unique case (s_q.st)
         ST_IDLE: begin
            if (start && cfg.block_len != 16'h0000) begin
               s_d.cfg  = cfg;
               s_d.sa   = cfg.src_addr;
               s_d.da   = cfg.dst_addr;
               s_d.left = cfg.block_len;
               s_d.idx  = 5'h00;
               s_d.st   = ST_SRC_WAIT;
            end
         end
         ST_SRC_WAIT: begin
            // Memory splits straight into bus transfers
            if (s_q.cfg.src_mem) begin
               s_d.len = txn_len(1'b0, s_q.cfg.burst_len, s_q.left);
               s_d.st  = ST_READ;
            end else if (sreq[1]) begin
               s_d.len = txn_len(sreq[0], s_q.cfg.burst_len,
                                 s_q.left);
               s_d.st  = ST_READ;
            end
         end
         ST_READ: begin
            if (bus_done) begin
               s_d.fifo[s_q.idx] = bus_rdata;
               s_d.sa = s_q.cfg.src_inc ? s_q.sa + `DMA_WORD_BYTES : s_q.sa;
               if (s_q.idx == 5'(s_q.len - 5'h01)) begin
                  s_d.idx     = 5'h00;
                  s_d.src_ack = !s_q.cfg.src_mem;
                  s_d.st      = ST_DST_WAIT;
               end else begin
                  s_d.idx = 5'(s_q.idx + 5'h01);
               end
            end
         end
         ST_DST_WAIT: begin
            if (s_q.cfg.dst_mem || dreq[1])
               s_d.st = ST_WRITE;
         end
         ST_WRITE: begin
            if (bus_done) begin
               s_d.da = s_q.cfg.dst_inc ? s_q.da + `DMA_WORD_BYTES : s_q.da;
               if (s_q.idx == 5'(s_q.len - 5'h01)) begin
                  s_d.idx     = 5'h00;
                  s_d.dst_ack = !s_q.cfg.dst_mem;
                  s_d.left    = 16'(s_q.left - {11'h000, s_q.len});
                  // Prefetch mode is moot: peripheral never ends a block
                  if (s_q.left == {11'h000, s_q.len}) begin
                     s_d.st   = ST_IDLE;
                     s_d.done = 1'b1;
                  end else begin
                     s_d.st = ST_SRC_WAIT;
                  end
               end else begin
                  s_d.idx = 5'(s_q.idx + 5'h01);
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bus_req.valid = (s_q.st == ST_READ) || (s_q.st == ST_WRITE);
   assign bus_req.write = (s_q.st == ST_WRITE);
   assign bus_req.mst   = bus_req.write ? s_q.cfg.dst_mst : s_q.cfg.src_mst;
   assign bus_req.addr  = bus_req.write ? s_q.da : s_q.sa;
   assign bus_req.wdata = s_q.fifo[s_q.idx];
   assign hs_ack  = ((s_q.src_ack && s_q.cfg.src_kind != HS_SW)
                     ? onehot(s_q.cfg.src_hs) : '0)
                  | ((s_q.dst_ack && s_q.cfg.dst_kind != HS_SW)
                     ? onehot(s_q.cfg.dst_hs) : '0);
   assign sw_ack  = (s_q.src_ack && s_q.cfg.src_kind == HS_SW)
                  || (s_q.dst_ack && s_q.cfg.dst_kind == HS_SW);
   assign active  = (s_q.st != ST_IDLE);
   assign done    = s_q.done;
   assign irq_evt = s_q.done && s_q.cfg.int_en;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_single_len: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.st == ST_SRC_WAIT && !s_q.cfg.src_mem && sreq == 2'b11
      |=> s_q.st == ST_READ && s_q.len == 5'h01)
      else $error("single transaction not one item");
   chk_mem_no_ack: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.src_ack |-> !s_q.cfg.src_mem)
      else $error("handshake ack toward memory source");
   chk_read_first: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.st == ST_DST_WAIT && $past(s_q.st) != ST_DST_WAIT
      |-> $past(s_q.st) == ST_READ && $past(bus_done))
      else $error("write phase without read");
   chk_self_off: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.st == ST_WRITE && bus_done && s_q.idx == 5'(s_q.len - 5'h01)
      && s_q.left == {11'h000, s_q.len}
      |=> s_q.st == ST_IDLE && done ##1 !done)
      else $error("channel not disabled at end of transfer");
   chk_fifo_store: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.st == ST_READ && bus_done
      |=> s_q.fifo[$past(s_q.idx)] == $past(bus_rdata))
      else $error("read data not stored in fifo");
   chk_pirq_req: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.st == ST_SRC_WAIT && !s_q.cfg.src_mem
      && s_q.cfg.src_kind == HS_PIRQ && !sreq[1]
      |=> s_q.st == ST_SRC_WAIT)
      else $error("interrupt mode moved without request");
   chk_sw_req: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.st == ST_SRC_WAIT && !s_q.cfg.src_mem
      && s_q.cfg.src_kind == HS_SW && !sw_req
      |=> s_q.st == ST_SRC_WAIT)
      else $error("software mode moved without request");
   cov_single: cover property (@(posedge mclk) disable iff (rst)
      s_q.st == ST_SRC_WAIT ##1 s_q.st == ST_READ && s_q.len == 5'h01);
   cov_done: cover property (@(posedge mclk) disable iff (rst) done);

endmodule

// ===== rtl/dma_pkg.sv
`include "dma_regs.svh"

package dma_pkg;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {HS_HW, HS_SW, HS_PIRQ} hs_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SRC_WAIT, ST_READ, ST_DST_WAIT, ST_WRITE
   } ch_state_t;

   // Per-channel setup, sampled when the channel is started
   typedef struct packed {
      logic [31:0] src_addr;
      logic [31:0] dst_addr;
      logic [15:0] block_len;
      logic [4:0]  burst_len;
      logic        src_mem;
      logic        dst_mem;
      logic [3:0]  src_hs;
      logic [3:0]  dst_hs;
      hs_kind_t    src_kind;
      hs_kind_t    dst_kind;
      logic        src_mst;
      logic        dst_mst;
      logic        src_inc;
      logic        dst_inc;
      logic        int_en;
   } ch_cfg_t;

   // Channel request toward a master port
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        mst;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bus_req_t;

   // Master port outputs
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mst_out_t;

endpackage

// ===== rtl/dma_regs.svh
`ifndef DMA_REGS_SVH
`define DMA_REGS_SVH

// ----------------------------------------------------------------
// Controller configuration
// ----------------------------------------------------------------
`define DMA_NUM_CH      4
`define DMA_NUM_MST     2
`define DMA_NUM_HS      11
`define DMA_FIFO_DEPTH  16
`define DMA_MAX_BURST   16
`define DMA_WORD_BYTES  32'h0000_0004
`define DMA_SINGLE_LEN  5'h01

`endif

// ===== rtl/general_dma_controller.sv
`timescale 1ns/10ps
`include "dma_regs.svh"
// Overview of operation
// - Four channels share two bus master ports for reads and writes.
// - Eleven hardware handshake interfaces plus software handshaking.
// - Controller alone fixes block length and ends each block.
// - One channel per pairing; each item is one read then one write.
// - Host sets up and controls channels through its setup port.
// - One interrupt output reports controller events.
// - Memory ends are always ready; no request or acknowledge.
// - Non-memory ends bind a run-time selectable handshake interface.
// - Source data goes into the channel FIFO, then to destination.
// - Requests come by hardware, software or peripheral interrupt.
// - Software handshaking requests come from software-driven bits.
// - Interrupt handshaking uses the request input only.
// - Prefetch mode matters only when destination controls flow.
// - Memory blocks split into bus transfers, others into transactions.
// - Transactions are single or burst, for non-memory ends only.
// - A single transaction is one item and one bus transfer.
// - At transfer end the channel disables itself and may interrupt.

module general_dma_controller
   import dma_pkg::*;
#(
   parameter int NUM_CH     = `DMA_NUM_CH,
   parameter int NUM_HS     = `DMA_NUM_HS,
   parameter int FIFO_DEPTH = `DMA_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rst,
   // Channel setup from host
   input  wire ch_cfg_t [NUM_CH-1:0]          cfg,
   input  wire logic [NUM_CH-1:0]             start,
   // Hardware handshake interfaces
   input  wire logic [NUM_HS-1:0]             hs_req,
   input  wire logic [NUM_HS-1:0]             hs_single,
   output logic [NUM_HS-1:0]                  hs_ack,
   // Software handshake per channel
   input  wire logic [NUM_CH-1:0]             sw_req,
   input  wire logic [NUM_CH-1:0]             sw_single,
   output logic [NUM_CH-1:0]                  sw_ack,
   // Bus master ports
   output mst_out_t [`DMA_NUM_MST-1:0]        m_out,
   input  wire logic [`DMA_NUM_MST-1:0]       m_ready,
   input  wire logic [`DMA_NUM_MST-1:0][31:0] m_rdata,
   // Status and interrupt
   output logic [NUM_CH-1:0]                  ch_active,
   output logic [NUM_CH-1:0]                  ch_done,
   output logic                               irq
);

   localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

   // Owner field and fixed-priority scan are sized for up to 8 channels
   if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_param
      $error("general_dma_controller: NUM_CH out of range");
   end

   typedef struct packed {
      mst_out_t [`DMA_NUM_MST-1:0]          mo;
      logic [`DMA_NUM_MST-1:0][CW-1:0]      owner;
      logic [NUM_HS-1:0]                    hs_ack;
      logic [NUM_CH-1:0]                    sw_ack;
      logic [NUM_CH-1:0]                    active;
      logic [NUM_CH-1:0]                    done;
      logic                                 irq;
   } top_t;

   top_t                     s_q;
   top_t                     s_d;
   bus_req_t [NUM_CH-1:0]    rq;
   logic [NUM_CH-1:0]        bus_done;
   logic [NUM_CH-1:0][31:0]  ch_rdata;
   logic [NUM_CH-1:0][NUM_HS-1:0] ch_hs_ack;
   logic [NUM_CH-1:0]        ch_sw_ack;
   logic [NUM_CH-1:0]        ch_act;
   logic [NUM_CH-1:0]        ch_fin;
   logic [NUM_CH-1:0]        ch_irq;

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      // Read data comes from whichever port the channel is using
      assign ch_rdata[c] = m_rdata[rq[c].mst];

      dma_channel #(
         .FIFO_DEPTH (FIFO_DEPTH),
         .NUM_HS     (NUM_HS)
      ) u_ch (
         .mclk      (mclk),
         .rst       (rst),
         .cfg       (cfg[c]),
         .start     (start[c]),
         .hs_req    (hs_req),
         .hs_single (hs_single),
         .sw_req    (sw_req[c]),
         .sw_single (sw_single[c]),
         .bus_req   (rq[c]),
         .bus_done  (bus_done[c]),
         .bus_rdata (ch_rdata[c]),
         .hs_ack    (ch_hs_ack[c]),
         .sw_ack    (ch_sw_ack[c]),
         .active    (ch_act[c]),
         .done      (ch_fin[c]),
         .irq_evt   (ch_irq[c])
      );
   end

   // ----------------------------------------------------------------
   // Master port arbitration and status
   // ----------------------------------------------------------------
   // A port is held until its transfer completes; lowest channel wins
   always_comb begin
      logic found;
      s_d      = s_q;
      bus_done = '0;
      found    = 1'b0;
      for (int m = 0; m < `DMA_NUM_MST; m++) begin
         found = 1'b0;
         if (s_q.mo[m].valid) begin
            if (m_ready[m]) begin
               s_d.mo[m].valid        = 1'b0;
               bus_done[s_q.owner[m]] = 1'b1;
            end
         end else begin
            for (int c = 0; c < NUM_CH; c++) begin
               if (!found && rq[c].valid && rq[c].mst == 1'(m)) begin
                  found          = 1'b1;
                  s_d.owner[m]   = CW'(c);
                  s_d.mo[m].valid = 1'b1;
                  s_d.mo[m].write = rq[c].write;
                  s_d.mo[m].addr  = rq[c].addr;
                  s_d.mo[m].wdata = rq[c].wdata;
               end
            end
         end
      end
      s_d.hs_ack = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         s_d.hs_ack = s_d.hs_ack | ch_hs_ack[c];
      end
      s_d.sw_ack = ch_sw_ack;
      s_d.active = ch_act;
      s_d.done   = ch_fin;
      s_d.irq    = |ch_irq;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Registered outputs
   assign m_out     = s_q.mo;
   assign hs_ack    = s_q.hs_ack;
   assign sw_ack    = s_q.sw_ack;
   assign ch_active = s_q.active;
   assign ch_done   = s_q.done;
   assign irq       = s_q.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_bus_hold: assert property (
      @(posedge mclk) disable iff (rst)
      m_out[0].valid && !m_ready[0]
      |=> m_out[0].valid && $stable(m_out[0].addr))
      else $error("master port dropped a pending transfer");
   chk_irq_cause: assert property (
      @(posedge mclk) disable iff (rst)
      irq |-> $past(|ch_irq) && $past(|ch_fin, 1))
      else $error("interrupt without channel completion");
   cov_both_ports: cover property (@(posedge mclk) disable iff (rst)
      m_out[0].valid && m_out[1].valid);

endmodule

// ===== testbench/bus_far_side.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Far side of the master ports: system bus with memory behind it
// ----------------------------------------------------------------
module bus_far_side
   import dma_pkg::*;
#(
   parameter int SLOW_WAIT = 15
) (
   // Clock and reset
   input  wire logic            mclk,
   input  wire logic            rst,
   // Controller master ports
   input  wire mst_out_t [1:0]  m_out,
   output logic [1:0]           m_ready,
   output logic [1:0][31:0]     m_rdata,
   // Test control and observation
   input  wire logic            slow,
   output logic [1:0][15:0]     rd_cnt,
   output logic [1:0][15:0]     wr_cnt,
   output logic [1:0][31:0]     last_waddr,
   output logic [1:0][31:0]     last_wdata
);
   logic [1:0][4:0] wait_q;
   logic [31:0]     cyc_q;

   // Data valid only with ready; a moving pattern otherwise
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         m_rdata[p] = m_ready[p] ? (m_out[p].addr ^ 32'h5A5A_0000) : ~cyc_q;
      end
   end

   // Slow mode adds 15 wait states, the most a memory end may add
   always_ff @(posedge mclk) begin
      cyc_q <= rst ? 32'h0 : cyc_q + 32'h1;
      for (int p = 0; p < 2; p++) begin
         if (rst) begin
            m_ready[p]    <= 1'b0;
            wait_q[p]     <= 5'h00;
            rd_cnt[p]     <= 16'h0000;
            wr_cnt[p]     <= 16'h0000;
            last_waddr[p] <= 32'h0;
            last_wdata[p] <= 32'h0;
         end else if (m_ready[p]) begin
            m_ready[p] <= 1'b0;
            wait_q[p]  <= 5'h00;
            if (m_out[p].write) begin
               wr_cnt[p]     <= wr_cnt[p] + 16'h0001;
               last_waddr[p] <= m_out[p].addr;
               last_wdata[p] <= m_out[p].wdata;
            end else begin
               rd_cnt[p] <= rd_cnt[p] + 16'h0001;
            end
         end else if (m_out[p].valid) begin
            if (wait_q[p] >= (slow ? 5'(SLOW_WAIT) : 5'h00)) begin
               m_ready[p] <= 1'b1;
            end else begin
               wait_q[p] <= wait_q[p] + 5'h01;
            end
         end
      end
   end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
   import dma_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic              mclk, rst, irq, slow;
   ch_cfg_t [3:0]     cfg;
   logic [3:0]        start, sw_req, sw_single, sw_ack, ch_active, ch_done;
   logic [10:0]       hs_req, hs_single, hs_ack;
   mst_out_t [1:0]    m_out;
   logic [1:0]        m_ready;
   logic [1:0][31:0]  m_rdata, last_waddr, last_wdata;
   logic [1:0][15:0]  rd_cnt, wr_cnt;
   int                num_errors, comparisons, irq_cnt;
   int                done_cnt [4];

   general_dma_controller dut (.mclk(mclk), .rst(rst), .cfg(cfg),
      .start(start), .hs_req(hs_req), .hs_single(hs_single),
      .hs_ack(hs_ack), .sw_req(sw_req), .sw_single(sw_single),
      .sw_ack(sw_ack), .m_out(m_out), .m_ready(m_ready),
      .m_rdata(m_rdata), .ch_active(ch_active), .ch_done(ch_done),
      .irq(irq));
   bus_far_side far (.mclk(mclk), .rst(rst), .m_out(m_out),
      .m_ready(m_ready), .m_rdata(m_rdata), .slow(slow), .rd_cnt(rd_cnt),
      .wr_cnt(wr_cnt), .last_waddr(last_waddr), .last_wdata(last_wdata));

   // ----------------------------------------------------------------
   // Clock and pulse counters
   // ----------------------------------------------------------------
   always #5 mclk = ~mclk;
   // Interrupt sink listens from time zero, before any channel is set up
   always @(posedge mclk) begin
      if (irq === 1'b1) irq_cnt++;
      for (int c = 0; c < 4; c++) if (ch_done[c] === 1'b1) done_cnt[c]++;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   function automatic ch_cfg_t mk(logic [31:0] sa, da, logic [15:0] len,
      logic [4:0] bl, logic sm, logic [3:0] sh, hs_kind_t sk,
      logic sx, dx, ie);
      ch_cfg_t k;
      k           = '0;
      k.src_addr  = sa;
      k.dst_addr  = da;
      k.block_len = len;
      k.burst_len = bl;
      k.src_mem   = sm;
      k.dst_mem   = 1'b1;
      k.src_hs    = sh;
      k.dst_hs    = 4'hF;
      k.src_kind  = sk;
      k.dst_kind  = HS_HW;
      k.src_mst   = sx;
      k.dst_mst   = dx;
      k.int_en    = ie;
      k.src_inc   = 1'b1;
      k.dst_inc   = 1'b1;
      return k;
   endfunction

   task automatic check(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("errors=%0d comparisons=%0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic go(input int c, input ch_cfg_t k);
      @(posedge mclk);
      cfg[c]   <= k;
      start[c] <= 1'b1;
      @(posedge mclk);
      start[c] <= 1'b0;
   endtask

   // Bounded waits; a negative index waits on the software ack
   task automatic wait_ack(input int c, input int h);
      for (int i = 0; i < 2000; i++) begin
         @(posedge mclk);
         if (h < 0 ? sw_ack[c] === 1'b1 : hs_ack[h] === 1'b1) return;
      end
      num_errors++;
      print_verdict();
   endtask

   task automatic wait_done(input int c);
      for (int i = 0; i < 2000; i++) begin
         @(posedge mclk);
         if (ch_done[c] === 1'b1) begin
            repeat (2) @(posedge mclk);
            return;
         end
      end
      num_errors++;
      print_verdict();
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Memory to memory across both ports, slowest memory timing
   task automatic s_mem_copy;
      logic [15:0] r, w;
      int          q, d;
      r = rd_cnt[0];
      w = wr_cnt[1];
      q = irq_cnt;
      d = done_cnt[0];
      slow <= 1'b1;
      go(0, mk(32'h100, 32'h200, 16'h3, 5'h1, 1'b1, 4'hF, HS_HW,
         1'b0, 1'b1, 1'b1));
      wait_done(0);
      check(32'(rd_cnt[0] - r), 32'h3);
      check(32'(wr_cnt[1] - w), 32'h3);
      check(last_waddr[1], 32'h0000_0208);
      check(last_wdata[1], 32'h5A5A_0108);
      check(32'(done_cnt[0] - d), 32'h1);
      check(32'(irq_cnt - q), 32'h1);
      check({31'h0, ch_active[0]}, 32'h0);
      slow <= 1'b0;
   endtask

   // Single requests on the top interface, one item per ack
   task automatic s_hw_single;
      logic [15:0] r;
      r = rd_cnt[0];
      hs_single[10] <= 1'b1;
      go(1, mk(32'h1000, 32'h2000, 16'h2, 5'h4, 1'b0, 4'hA, HS_HW,
         1'b0, 1'b0, 1'b0));
      repeat (20) @(posedge mclk);
      check(32'(rd_cnt[0] - r), 32'h0);
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk);
         hs_req[10] <= 1'b1;
         wait_ack(1, 10);
         hs_req[10] <= 1'b0;
         check(32'(rd_cnt[0] - r), 32'(i + 1));
      end
      wait_done(1);
      check(last_wdata[0], 32'h5A5A_1004);
      hs_single[10] <= 1'b0;
   endtask

   // A burst of 4, one single, then a burst cut to the 1 item left
   task automatic s_sw_burst;
      logic [15:0] r, w;
      int          q;
      r = rd_cnt[1];
      w = wr_cnt[1];
      q = irq_cnt;
      go(2, mk(32'h3000, 32'h4000, 16'h6, 5'h4, 1'b0, 4'hF, HS_SW,
         1'b1, 1'b1, 1'b0));
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         sw_req[2]    <= 1'b1;
         sw_single[2] <= (i == 1);
         wait_ack(2, -1);
         sw_req[2]    <= 1'b0;
         sw_single[2] <= 1'b0;
         check(32'(rd_cnt[1] - r), 32'(4 + i));
      end
      wait_done(2);
      check(32'(wr_cnt[1] - w), 32'h6);
      check(32'(irq_cnt - q), 32'h0);
   endtask

   // Interrupt handshake: the single input must be ignored
   task automatic s_pirq;
      logic [15:0] r;
      int          d;
      r = rd_cnt[1];
      d = done_cnt[3];
      hs_single[3] <= 1'b1;
      go(3, mk(32'h5000, 32'h6000, 16'h2, 5'h2, 1'b0, 4'h3, HS_PIRQ,
         1'b1, 1'b0, 1'b1));
      repeat (5) @(posedge mclk);
      check(32'(rd_cnt[1] - r), 32'h0);
      hs_req[3] <= 1'b1;
      wait_ack(3, 3);
      hs_req[3] <= 1'b0;
      check(32'(rd_cnt[1] - r), 32'h2);
      wait_done(3);
      check(32'(done_cnt[3] - d), 32'h1);
      hs_single[3] <= 1'b0;
   endtask

   // Memory source, destination paced by hardware interface 5
   task automatic s_hw_dst;
      logic [15:0] r, w;
      int          d;
      ch_cfg_t     k;
      r = rd_cnt[0];
      w = wr_cnt[0];
      d = done_cnt[0];
      k = mk(32'h7000, 32'h8000, 16'h2, 5'h2, 1'b1, 4'hF, HS_HW,
         1'b0, 1'b0, 1'b0);
      k.dst_mem = 1'b0;
      k.dst_hs  = 4'h5;
      go(0, k);
      repeat (20) @(posedge mclk);
      check(32'(rd_cnt[0] - r), 32'h2);
      check(32'(wr_cnt[0] - w), 32'h0);
      hs_req[5] <= 1'b1;
      wait_ack(0, 5);
      hs_req[5] <= 1'b0;
      check(32'(wr_cnt[0] - w), 32'h2);
      check(last_wdata[0], 32'h5A5A_7004);
      // Done pulses with the ack, so it is counted, not waited for
      repeat (2) @(posedge mclk);
      check(32'(done_cnt[0] - d), 32'h1);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      mclk        = 1'b0;
      rst         = 1'b1;
      slow        = 1'b0;
      cfg         = '0;
      start       = '0;
      sw_req      = '0;
      sw_single   = '0;
      hs_req      = '0;
      hs_single   = '0;
      num_errors  = 0;
      comparisons = 0;
      irq_cnt     = 0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      s_mem_copy();
      s_hw_single();
      s_sw_burst();
      s_pirq();
      s_hw_dst();
      // Every channel must be quiet before the system may sleep
      check({28'h0, ch_active}, 32'h0);
      print_verdict();
   end
endmodule
